/* hdl/usbt_matcher.v */
// usb protocol trigger matcher with register port and interrupt
// ==========================================================
// Functional notes
// - every speed offers sync, reset, suspend, resume, eop, token, data, handshake, special and error triggers.
// - token trigger takes any token or sof, out, in, setup, with an address qualifier except on sof.
// - the token address is compared by le, lt, eq, gt, ge, ne or an inside or outside range.
// - sof frame numbers match a pattern whose bits may each be don't care.
// - data trigger takes any data pid or one of them; data2 and mdata only at high speed.
// - the data payload may be qualified by the same six relations or a range test.
// - handshake trigger takes any, ack, nak or stall; nyet only at high speed.
// - special trigger takes any or one pid; reserved always, pre at full speed, err, split and ping at high speed.
// - pid check, crc5 and crc16 errors trigger at every speed, bit stuffing only at low and full speed.
// - split packets are qualified by hub address, port address and start or complete, each maybe don't care.
// - split start and end bits are qualified or don't care, covering speed and isochronous positions.
// - split endpoint type is qualified as don't care, control, isochronous, bulk or interrupt.
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "usbt_regs.vh"

// ==========================================================
// relational and range comparator
module usbt_cmp #(
    parameter W = 8
) (
    // operands
    input wire [W-1:0] val_in,
    input wire [W-1:0] lo_in,
    input wire [W-1:0] hi_in,
    input wire [2:0] op_in,

    // result
    output reg hit_out
);
    wire in_rng;

    assign in_rng = (val_in >= lo_in) && (val_in <= hi_in);
    always @* begin
        case (op_in)
            `USBT_OP_LE: hit_out = (val_in <= lo_in);
            `USBT_OP_LT: hit_out = (val_in < lo_in);
            `USBT_OP_EQ: hit_out = (val_in == lo_in);
            `USBT_OP_GT: hit_out = (val_in > lo_in);
            `USBT_OP_GE: hit_out = (val_in >= lo_in);
            `USBT_OP_NE: hit_out = (val_in != lo_in);
            `USBT_OP_IN: hit_out = in_rng;
            `USBT_OP_OUT: hit_out = ~in_rng;
            default: hit_out = 1'b0;
        endcase
    end
endmodule // usbt_cmp

// ==========================================================
// top level matcher
module usbt_matcher (
    // clock and reset
    input wire sys_clk_in,
    input wire rst_n_in,

    // register port
    input wire [7:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [31:0] reg_rdata_out,

    // decoded bus events, one-cycle pulses
    input wire ev_sync_in,
    input wire ev_reset_in,
    input wire ev_suspend_in,
    input wire ev_resume_in,
    input wire ev_eop_in,

    // decoded packet, fields valid with pkt_valid_in
    input wire pkt_valid_in,
    input wire [3:0] pkt_pid_in,
    input wire [6:0] pkt_addr_in,
    input wire [10:0] pkt_frame_in,
    input wire [31:0] pkt_data_in,
    input wire [6:0] pkt_hub_in,
    input wire pkt_sc_in,
    input wire [6:0] pkt_port_in,
    input wire pkt_s_in,
    input wire pkt_e_in,
    input wire [1:0] pkt_et_in,

    // decoder error pulses
    input wire err_pid_in,
    input wire err_crc5_in,
    input wire err_crc16_in,
    input wire err_stuff_in,

    // results
    output reg trig_out,
    output wire irq_out
);

    // ======================================================
    // registers
    reg [24:0] ctrl;
    reg [14:0] addr_cfg;
    reg [26:0] frame_cfg;
    reg [31:0] data_lo;
    reg [31:0] data_hi;
    reg [23:0] split_cfg;
    reg [2:0] status;
    reg [2:0] irq_en;
    reg [15:0] trig_cnt;

    // ======================================================
    // control fields
    wire ctl_en;
    wire [1:0] spd;
    wire [3:0] evt_sel;
    wire [3:0] pid_sel;
    wire sel_any;
    wire aq_en;
    wire [2:0] aop;
    wire dq_en;
    wire [2:0] dop;
    wire [3:0] err_sel;
    wire hs;

    assign ctl_en = ctrl[`USBT_CTRL_EN];
    assign spd = ctrl[`USBT_CTRL_SPD_LSB+1:`USBT_CTRL_SPD_LSB];
    assign evt_sel = ctrl[`USBT_CTRL_EVT_LSB+3:`USBT_CTRL_EVT_LSB];
    assign pid_sel = ctrl[`USBT_CTRL_PID_LSB+3:`USBT_CTRL_PID_LSB];
    assign sel_any = ctrl[`USBT_CTRL_ANY];
    assign aq_en = ctrl[`USBT_CTRL_AQ_EN];
    assign aop = ctrl[`USBT_CTRL_AOP_LSB+2:`USBT_CTRL_AOP_LSB];
    assign dq_en = ctrl[`USBT_CTRL_DQ_EN];
    assign dop = ctrl[`USBT_CTRL_DOP_LSB+2:`USBT_CTRL_DOP_LSB];
    assign err_sel = ctrl[`USBT_CTRL_ERR_LSB+3:`USBT_CTRL_ERR_LSB];
    assign hs = (spd == `USBT_SPD_HS);

    // ======================================================
    // pid availability per speed
    reg pid_ok;

    always @* begin
        case (pkt_pid_in)
            `USBT_PID_DATA2: pid_ok = hs;
            `USBT_PID_MDATA: pid_ok = hs;
            `USBT_PID_NYET: pid_ok = hs;
            `USBT_PID_PRE: pid_ok = (spd != `USBT_SPD_LS);
            `USBT_PID_SPLIT: pid_ok = hs;
            `USBT_PID_PING: pid_ok = hs;
            default: pid_ok = 1'b1;
        endcase
    end

    // shared code 1100 is pre at full speed and err at high speed
    wire [1:0] pkt_cls;
    wire cls_hit;
    wire pid_hit;

    assign pkt_cls = pkt_pid_in[1:0];
    assign cls_hit = pkt_valid_in & pid_ok & (sel_any | (pkt_pid_in == pid_sel));
    assign pid_hit = cls_hit;

    // ======================================================
    // qualifiers
    wire addr_cmp;
    wire data_cmp;

    usbt_cmp #(
        .W(7)
    ) u_addr_cmp (
        .val_in(pkt_addr_in),
        .lo_in(addr_cfg[6:0]),
        .hi_in(addr_cfg[14:8]),
        .op_in(aop),
        .hit_out(addr_cmp)
    );
    usbt_cmp #(
        .W(32)
    ) u_data_cmp (
        .val_in(pkt_data_in),
        .lo_in(data_lo),
        .hi_in(data_hi),
        .op_in(dop),
        .hit_out(data_cmp)
    );

    wire is_sof;
    wire addr_ok;
    wire frame_ok;
    wire data_ok;
    assign is_sof = (pkt_pid_in == `USBT_PID_SOF);
    // sof carries a frame number, not an address
    assign addr_ok = is_sof | ~aq_en | addr_cmp;
    // radix entry is a software matter; pattern and care mask are binary
    assign frame_ok = ~is_sof |
        (((pkt_frame_in ^ frame_cfg[10:0]) & frame_cfg[26:16]) == 11'h000);
    assign data_ok = ~dq_en | data_cmp;

    // split qualifiers, each with a care bit
    wire hub_ok;
    wire port_ok;
    wire sc_ok;
    wire se_ok;
    wire et_ok;
    wire split_ok;

    assign hub_ok = ~split_cfg[`USBT_SP_HUB_CARE] |
        (pkt_hub_in == split_cfg[6:0]);
    assign port_ok = ~split_cfg[`USBT_SP_PORT_CARE] |
        (pkt_port_in == split_cfg[`USBT_SP_PORT_LSB+6:`USBT_SP_PORT_LSB]);
    assign sc_ok = ~split_cfg[`USBT_SP_SC_CARE] |
        (pkt_sc_in == split_cfg[`USBT_SP_SC]);
    // s/e encode device speed or isochronous data position
    assign se_ok = ~split_cfg[`USBT_SP_SE_CARE] |
        ((pkt_s_in == split_cfg[`USBT_SP_S]) &
         (pkt_e_in == split_cfg[`USBT_SP_E]));
    assign et_ok = ~split_cfg[`USBT_SP_ET_CARE] |
        (pkt_et_in == split_cfg[`USBT_SP_ET_LSB+1:`USBT_SP_ET_LSB]);
    assign split_ok = (pkt_pid_in != `USBT_PID_SPLIT) |
        (hub_ok & port_ok & sc_ok & se_ok & et_ok);

    // ======================================================
    // errors
    wire stuff_hit;
    wire err_hit;

    // high speed stuffing faults are not a trigger source
    assign stuff_hit = err_stuff_in & ~hs & err_sel[3];
    assign err_hit = (err_pid_in & err_sel[0]) |
        (err_crc5_in & err_sel[1]) |
        (err_crc16_in & err_sel[2]) | stuff_hit;

    // ======================================================
    // event selection
    reg match;

    always @* begin
        case (evt_sel)
            `USBT_EV_SYNC: match = ev_sync_in;
            `USBT_EV_RESET: match = ev_reset_in;
            `USBT_EV_SUSP: match = ev_suspend_in;
            `USBT_EV_RESUME: match = ev_resume_in;
            `USBT_EV_EOP: match = ev_eop_in;
            `USBT_EV_TOKEN: match = pid_hit & (pkt_cls == `USBT_CLS_TOKEN) &
                addr_ok & frame_ok;
            `USBT_EV_DATA: match = pid_hit & (pkt_cls == `USBT_CLS_DATA) &
                data_ok;
            `USBT_EV_HAND: match = pid_hit & (pkt_cls == `USBT_CLS_HAND);
            `USBT_EV_SPEC: match = pid_hit & (pkt_cls == `USBT_CLS_SPEC) &
                split_ok;
            `USBT_EV_ERROR: match = err_hit;
            default: match = 1'b0;
        endcase
    end

    wire next_trig;
    assign next_trig = ctl_en & match;

    // ======================================================
    // register writes and trigger state
    wire wr_ctrl;
    wire wr_clr;
    wire [2:0] clr_bits;
    wire [2:0] set_bits;
    wire cnt_full;

    assign wr_ctrl = reg_wr_in & (reg_addr_in == `USBT_CTRL_OFF);
    assign wr_clr = reg_wr_in & (reg_addr_in == `USBT_CLR_OFF);
    assign clr_bits = wr_clr ? reg_wdata_in[2:0] : 3'h0;
    // saturate rather than wrap so a long run never reads low
    assign cnt_full = (trig_cnt == 16'hFFFF);
    assign set_bits = {next_trig & cnt_full, err_hit, next_trig};

    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl <= 25'h0000000;
            addr_cfg <= 15'h0000;
            frame_cfg <= 27'h0000000;
            data_lo <= 32'h00000000;
            data_hi <= 32'h00000000;
            split_cfg <= 24'h000000;
            irq_en <= 3'h0;
            status <= 3'h0;
            trig_cnt <= 16'h0000;
            trig_out <= 1'b0;
        end else begin
            trig_out <= next_trig;
            // set wins over a clear in the same cycle
            status <= (status & ~clr_bits) | set_bits;
            if (next_trig && !cnt_full) begin
                trig_cnt <= trig_cnt + 16'h0001;
            end
            if (wr_ctrl) begin
                ctrl <= reg_wdata_in[24:0];
            end
            if (reg_wr_in) begin
                case (reg_addr_in)
                    `USBT_ADDR_OFF: addr_cfg <= reg_wdata_in[14:0];
                    `USBT_FRAME_OFF: frame_cfg <= reg_wdata_in[26:0];
                    `USBT_DLO_OFF: data_lo <= reg_wdata_in;
                    `USBT_DHI_OFF: data_hi <= reg_wdata_in;
                    `USBT_SPLIT_OFF: split_cfg <= reg_wdata_in[23:0];
                    `USBT_IEN_OFF: irq_en <= reg_wdata_in[2:0];
                    default: irq_en <= irq_en;
                endcase
            end
            // writing the count register restarts it
            if (reg_wr_in && (reg_addr_in == `USBT_CNT_OFF)) begin
                trig_cnt <= 16'h0000;
            end
        end
    end

    assign irq_out = |(status & irq_en);

    // ======================================================
    // register reads, data one cycle after the strobe
    reg [31:0] next_rdata;
    always @* begin
        next_rdata = 32'h00000000;
        case (reg_addr_in)
            `USBT_CTRL_OFF: next_rdata = {7'h00, ctrl};
            `USBT_ADDR_OFF: next_rdata = {17'h00000, addr_cfg};
            `USBT_FRAME_OFF: next_rdata = {5'h00, frame_cfg};
            `USBT_DLO_OFF: next_rdata = data_lo;
            `USBT_DHI_OFF: next_rdata = data_hi;
            `USBT_SPLIT_OFF: next_rdata = {8'h00, split_cfg};
            `USBT_STAT_OFF: next_rdata = {29'h00000000, status};
            `USBT_IEN_OFF: next_rdata = {29'h00000000, irq_en};
            `USBT_CNT_OFF: next_rdata = {16'h0000, trig_cnt};
            default: next_rdata = 32'h00000000;
        endcase
    end

    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 32'h00000000;
        end else if (reg_rd_in) begin
            reg_rdata_out <= next_rdata;
        end else begin
            reg_rdata_out <= 32'h00000000;
        end
    end

endmodule // usbt_matcher

/* hdl/usbt_regs.vh */
// register offsets, field positions and codes of the usb trigger matcher
`ifndef USBT_REGS_VH
`define USBT_REGS_VH

// ==========================================================
// register offsets
`define USBT_CTRL_OFF 8'h00
`define USBT_ADDR_OFF 8'h04
`define USBT_FRAME_OFF 8'h08
`define USBT_DLO_OFF 8'h0C
`define USBT_DHI_OFF 8'h10
`define USBT_SPLIT_OFF 8'h14
`define USBT_STAT_OFF 8'h18
`define USBT_CLR_OFF 8'h1C
`define USBT_IEN_OFF 8'h20
`define USBT_CNT_OFF 8'h24

// ==========================================================
// ctrl fields
`define USBT_CTRL_EN 0
`define USBT_CTRL_SPD_LSB 1
`define USBT_CTRL_EVT_LSB 3
`define USBT_CTRL_PID_LSB 8
`define USBT_CTRL_ANY 12
`define USBT_CTRL_AQ_EN 13
`define USBT_CTRL_AOP_LSB 14
`define USBT_CTRL_DQ_EN 17
`define USBT_CTRL_DOP_LSB 18
`define USBT_CTRL_ERR_LSB 21

// ==========================================================
// split qualifier fields
`define USBT_SP_HUB_CARE 7
`define USBT_SP_PORT_LSB 8
`define USBT_SP_PORT_CARE 15
`define USBT_SP_SC 16
`define USBT_SP_SC_CARE 17
`define USBT_SP_S 18
`define USBT_SP_E 19
`define USBT_SP_SE_CARE 20
`define USBT_SP_ET_LSB 21
`define USBT_SP_ET_CARE 23

// ==========================================================
// status bits
`define USBT_ST_TRIG 0
`define USBT_ST_ERR 1
`define USBT_ST_OVF 2

// ==========================================================
// speeds
`define USBT_SPD_LS 2'h0
`define USBT_SPD_FS 2'h1
`define USBT_SPD_HS 2'h2

// ==========================================================
// event selections
`define USBT_EV_SYNC 4'h0
`define USBT_EV_RESET 4'h1
`define USBT_EV_SUSP 4'h2
`define USBT_EV_RESUME 4'h3
`define USBT_EV_EOP 4'h4
`define USBT_EV_TOKEN 4'h5
`define USBT_EV_DATA 4'h6
`define USBT_EV_HAND 4'h7
`define USBT_EV_SPEC 4'h8
`define USBT_EV_ERROR 4'h9

// ==========================================================
// packet identifiers and classes
`define USBT_PID_OUT 4'h1
`define USBT_PID_IN 4'h9
`define USBT_PID_SOF 4'h5
`define USBT_PID_SETUP 4'hD
`define USBT_PID_DATA2 4'h7
`define USBT_PID_MDATA 4'hF
`define USBT_PID_NYET 4'h6
`define USBT_PID_PRE 4'hC
`define USBT_PID_SPLIT 4'h8
`define USBT_PID_PING 4'h4
`define USBT_CLS_SPEC 2'h0
`define USBT_CLS_TOKEN 2'h1
`define USBT_CLS_HAND 2'h2
`define USBT_CLS_DATA 2'h3

// ==========================================================
// comparison operators
`define USBT_OP_LE 3'h0
`define USBT_OP_LT 3'h1
`define USBT_OP_EQ 3'h2
`define USBT_OP_GT 3'h3
`define USBT_OP_GE 3'h4
`define USBT_OP_NE 3'h5
`define USBT_OP_IN 3'h6
`define USBT_OP_OUT 3'h7

`endif

/* tb/usbt_bus_model.sv */
// model of the decoded usb bus feeding the matcher
`timescale 1ns/100ps
module usbt_bus_model (
    // clock
    input wire sys_clk_in,
    // decoded bus side
    output logic [4:0] ev_out,
    output logic [3:0] err_out,
    output logic pkt_valid_out,
    output logic [3:0] pid_out,
    output logic [68:0] fld_out
);
    initial begin
        ev_out = 5'h00;
        err_out = 4'h0;
        pkt_valid_out = 1'b0;
        pid_out = 4'h0;
        fld_out = 69'h0;
    end
    // ==========================================================
    // one-cycle event, error or packet
    task send(input [4:0] e_v, input [3:0] e_r, input p_v, input [3:0] p,
              input [68:0] f);
        @(posedge sys_clk_in);
        ev_out <= e_v;
        err_out <= e_r;
        pkt_valid_out <= p_v;
        pid_out <= p;
        fld_out <= f;
        @(posedge sys_clk_in);
        ev_out <= 5'h00;
        err_out <= 4'h0;
        pkt_valid_out <= 1'b0;
        // stale fields inverted so a late sample never matches by luck
        pid_out <= ~p;
        fld_out <= ~f;
    endtask
endmodule // usbt_bus_model

/* tb/usbt_matcher_sva.sv */
// port-level assertion checker for the usb trigger matcher
`timescale 1ns/100ps
`include "usbt_regs.vh"
module usbt_matcher_sva (
    // clock and reset
    input wire sys_clk_in,
    input wire rst_n_in,
    // register port
    input wire [7:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [31:0] reg_rdata_out,
    // packet and error side
    input wire pkt_valid_in,
    input wire [3:0] pkt_pid_in,
    input wire err_pid_in,
    input wire err_crc5_in,
    input wire err_crc16_in,
    input wire err_stuff_in,
    // results
    input wire trig_out,
    input wire irq_out
);
    // ==========================================================
    // control shadow, rebuilt from the write port
    reg [31:0] ctrl;
    wire errs = err_pid_in | err_crc5_in | err_crc16_in;
    wire hs = ctrl[2:1] == `USBT_SPD_HS;
    wire [3:0] evt = ctrl[6:3];
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            ctrl <= 32'h0;
        else if (reg_wr_in && reg_addr_in == `USBT_CTRL_OFF)
            ctrl <= reg_wdata_in;
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    // ==========================================================
    // trigger relations
    property p_disabled;
        !ctrl[0] |=> !trig_out;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("trigger while disabled");
    property p_any_token;
        ctrl[0] && evt == `USBT_EV_TOKEN && ctrl[12] && !ctrl[13]
            && pkt_valid_in && pkt_pid_in inside {4'h1, 4'h9, 4'hD}
            |=> trig_out;
    endproperty
    a_any_token: assert property (p_any_token)
        else $error("token missed");
    property p_hs_pid;
        !hs && pkt_valid_in && evt inside {[4'h5:4'h8]}
            && pkt_pid_in inside {4'h4, 4'h6, 4'h7, 4'h8, 4'hF} |=> !trig_out;
    endproperty
    a_hs_pid: assert property (p_hs_pid)
        else $error("high speed pid matched at lower speed");
    property p_pre_ls;
        ctrl[2:1] == `USBT_SPD_LS && pkt_valid_in && pkt_pid_in == 4'hC
            && evt inside {[4'h5:4'h8]} |=> !trig_out;
    endproperty
    a_pre_ls: assert property (p_pre_ls)
        else $error("pre matched at low speed");
    property p_stuff_hs;
        hs && evt == `USBT_EV_ERROR && err_stuff_in && !errs |=> !trig_out;
    endproperty
    a_stuff_hs: assert property (p_stuff_hs)
        else $error("stuffing error at high speed");
    property p_stuff_fs;
        ctrl[0] && !hs && evt == `USBT_EV_ERROR && ctrl[24] && err_stuff_in
            |=> trig_out;
    endproperty
    a_stuff_fs: assert property (p_stuff_fs)
        else $error("stuffing error missed");
    // ==========================================================
    // register port and interrupt
    property p_rd_idle;
        reg_rdata_out != 32'h0 |-> $past(reg_rd_in);
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read slot");
    property p_rd_zero;
        reg_rd_in && (reg_addr_in == `USBT_CLR_OFF || reg_addr_in > 8'h24
            || reg_addr_in[1:0] != 2'h0) |=> reg_rdata_out == 32'h0;
    endproperty
    a_rd_zero: assert property (p_rd_zero)
        else $error("unmapped or clear read not zero");
    property p_irq_rise;
        $rose(irq_out) |-> trig_out || $past(reg_wr_in)
            || $past(errs | err_stuff_in);
    endproperty
    a_irq_rise: assert property (p_irq_rise)
        else $error("interrupt without cause");
endmodule // usbt_matcher_sva

bind usbt_matcher usbt_matcher_sva u_usbt_matcher_sva (.*);

/* tb/usbt_matcher_tb.sv */
// self-checking bench for the usb trigger matcher
`timescale 1ns/100ps
`include "usbt_regs.vh"
module usbt_matcher_tb;
    // ==========================================================
    // stimulus and observation
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    wire [31:0] rdata;
    wire trig;
    wire irq;
    wire [4:0] ev;
    wire [3:0] er;
    wire pv;
    wire [3:0] pid;
    wire [68:0] fld;
    int compares = 0;
    int miscompares = 0;
    int ncnt = 0;
    int cyc = 0;
    int ev_map[4] = '{8, 5, 7, 6};
    always #4 clk = ~clk;
    // run far longer than the tests need only on a hang
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            conclude();
        end
    end
    usbt_matcher u_usbt_matcher (
        .sys_clk_in(clk), .rst_n_in(rst_n),
        .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
        .ev_sync_in(ev[0]), .ev_reset_in(ev[1]), .ev_suspend_in(ev[2]),
        .ev_resume_in(ev[3]), .ev_eop_in(ev[4]),
        .pkt_valid_in(pv), .pkt_pid_in(pid), .pkt_addr_in(fld[49:43]),
        .pkt_frame_in(fld[42:32]), .pkt_data_in(fld[31:0]),
        .pkt_hub_in(fld[56:50]), .pkt_sc_in(fld[64]),
        .pkt_port_in(fld[63:57]), .pkt_s_in(fld[65]), .pkt_e_in(fld[66]),
        .pkt_et_in(fld[68:67]), .err_pid_in(er[0]), .err_crc5_in(er[1]),
        .err_crc16_in(er[2]), .err_stuff_in(er[3]),
        .trig_out(trig), .irq_out(irq)
    );
    usbt_bus_model u_usbt_bus_model (
        .sys_clk_in(clk), .ev_out(ev), .err_out(er), .pkt_valid_out(pv),
        .pid_out(pid), .fld_out(fld)
    );
    // ==========================================================
    // expectations
    function [31:0] ctl(input [1:0] s, input [3:0] e, input [3:0] p,
                        input any, input [31:0] x);
        ctl = {19'h0, any, p, 1'b0, e, s, 1'b1} | x;
    endfunction
    function bit ok_pid(input [1:0] s, input [3:0] p);
        if (p inside {4'h4, 4'h6, 4'h7, 4'h8, 4'hF})
            return s == 2'h2;
        return p != 4'hC || s != 2'h0;
    endfunction
    function bit cmp(input [2:0] op, input [31:0] v, input [31:0] lo,
                     input [31:0] hi);
        case (op)
            `USBT_OP_LE: return v <= lo;
            `USBT_OP_LT: return v < lo;
            `USBT_OP_EQ: return v == lo;
            `USBT_OP_GT: return v > lo;
            `USBT_OP_GE: return v >= lo;
            `USBT_OP_NE: return v != lo;
            `USBT_OP_IN: return v >= lo && v <= hi;
            default: return v < lo || v > hi;
        endcase
    endfunction
    function bit spl(input [31:0] sr, input [68:0] f);
        return (!sr[7] || f[56:50] == sr[6:0])
            && (!sr[15] || f[63:57] == sr[14:8])
            && (!sr[17] || f[64] == sr[16])
            && (!sr[20] || f[66:65] == sr[19:18])
            && (!sr[23] || f[68:67] == sr[22:21]);
    endfunction
    function [68:0] rf();
        rf = {5'($urandom), $urandom, $urandom};
    endfunction
    // ==========================================================
    // drivers and comparison
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task rd(input [7:0] a, output [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask
    task go(input [4:0] e_v, input [3:0] e_r, input p_v, input [3:0] p,
            input [68:0] f, input bit e);
        u_usbt_bus_model.send(e_v, e_r, p_v, p, f);
        #1 chk("trigger", trig, e);
        ncnt += e;
        @(posedge clk);
        #1 chk("trigger end", trig, 1'b0);
    endtask
    task pk(input [3:0] p, input [68:0] f, input bit e);
        go(5'h00, 4'h0, 1'b1, p, f, e);
    endtask
    task conclude;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        logic [31:0] r, lo, hi, v, sr, c;
        logic [68:0] f;
        logic [10:0] pat, msk, fr;
        bit ok;
        int i;
        void'($urandom(94355));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        wr(`USBT_STAT_OFF, 32'hFFFFFFFF);
        wr(8'h28, 32'hFFFFFFFF);
        for (int a = 0; a <= 40; a += 4) begin
            rd(8'(a), r);
            chk("reset read", r, 32'h0);
        end
        rd(8'h01, r);
        chk("misaligned read", r, 32'h0);
        for (int s = 0; s < 3; s++)
            for (int k = 0; k < 5; k++) begin
                wr(`USBT_CTRL_OFF, ctl(2'(s), 4'(k), 4'h0, 1'b0, 32'h0));
                go(5'h01 << k, 4'h0, 1'b0, 4'h0, rf(), 1'b1);
                go(5'h01 << ((k + 1) % 5), 4'h0, 1'b0, 4'h0, rf(), 1'b0);
            end
        for (int s = 0; s < 3; s++)
            for (int p = 0; p < 16; p++) begin
                c = ctl(2'(s), 4'(ev_map[p % 4]), 4'(p), 1'b0, 32'h0);
                ok = ok_pid(2'(s), 4'(p));
                wr(`USBT_CTRL_OFF, c | 32'h1000);
                pk(4'(p), rf(), ok);
                wr(`USBT_CTRL_OFF, c);
                pk(4'(p), rf(), ok);
                pk(4'(p ^ 4), rf(), 1'b0);
            end
        wr(`USBT_CTRL_OFF, ctl(2'h2, 4'h7, 4'h0, 1'b1, 32'h0) & ~32'h1);
        pk(4'h2, rf(), 1'b0);
        for (int op = 0; op < 8; op++)
            repeat (3) begin
                lo = $urandom % 100 + 1;
                hi = lo + 10;
                v = lo - 1 + $urandom % 13;
                f = rf();
                f[49:43] = v[6:0];
                f[31:0] = v;
                wr(`USBT_ADDR_OFF, {17'h0, hi[6:0], 1'b0, lo[6:0]});
                c = 32'(op) << 14 | 32'h2000;
                wr(`USBT_CTRL_OFF, ctl(2'h1, 4'h5, 4'h9, 1'b0, c));
                pk(4'h9, f, cmp(3'(op), v, lo, hi));
                wr(`USBT_DLO_OFF, lo);
                wr(`USBT_DHI_OFF, hi);
                c = 32'(op) << 18 | 32'h20000;
                wr(`USBT_CTRL_OFF, ctl(2'h2, 4'h6, 4'h0, 1'b1, c));
                pk(4'h3, f, cmp(3'(op), v, lo, hi));
            end
        repeat (12) begin
            pat = 11'($urandom);
            msk = 11'($urandom);
            fr = $urandom % 2 ? pat ^ (11'($urandom) & ~msk) : 11'($urandom);
            f = rf();
            f[42:32] = fr;
            wr(`USBT_FRAME_OFF, {5'h0, msk, 5'h0, pat});
            c = ctl(2'($urandom % 3), 4'h5, 4'h5, 1'b0, 32'h0);
            wr(`USBT_CTRL_OFF, c);
            pk(4'h5, f, ((fr ^ pat) & msk) == 11'h0);
        end
        for (int s = 0; s < 3; s++)
            for (int e = 0; e < 4; e++) begin
                c = ctl(2'(s), 4'h9, 4'h0, 1'b0, 32'h1 << (21 + e));
                wr(`USBT_CTRL_OFF, c);
                go(5'h00, 4'h1 << e, 1'b0, 4'h0, rf(), e != 3 || s != 2);
                go(5'h00, 4'h1 << ((e + 1) % 4), 1'b0, 4'h0, rf(), 1'b0);
            end
        rd(`USBT_STAT_OFF, r);
        chk("error status", r, 32'h3);
        wr(`USBT_CTRL_OFF, ctl(2'h2, 4'h8, 4'h8, 1'b0, 32'h0));
        repeat (16) begin
            sr = $urandom;
            f = rf();
            f[68:50] = {sr[22:21], sr[19:18], sr[16], sr[14:8], sr[6:0]};
            if ($urandom % 2) begin
                i = 50 + $urandom % 19;
                f[i] = ~f[i];
            end
            wr(`USBT_SPLIT_OFF, sr);
            pk(4'h8, f, spl(sr, f));
        end
        wr(`USBT_CLR_OFF, 32'h7);
        wr(`USBT_IEN_OFF, 32'h1);
        #1 chk("irq idle", irq, 1'b0);
        wr(`USBT_CTRL_OFF, ctl(2'h0, 4'h4, 4'h0, 1'b0, 32'h0));
        go(5'h10, 4'h0, 1'b0, 4'h0, rf(), 1'b1);
        chk("irq set", irq, 1'b1);
        rd(`USBT_STAT_OFF, r);
        chk("status", r, 32'h1);
        wr(`USBT_CLR_OFF, 32'h1);
        #1 chk("irq clear", irq, 1'b0);
        wr(`USBT_IEN_OFF, 32'h0);
        go(5'h10, 4'h0, 1'b0, 4'h0, rf(), 1'b1);
        chk("irq masked", irq, 1'b0);
        rd(`USBT_CNT_OFF, r);
        chk("count", r, ncnt);
        wr(`USBT_CNT_OFF, 32'h0);
        rd(`USBT_CNT_OFF, r);
        chk("count zeroed", r, 32'h0);
        wr(`USBT_CTRL_OFF, 32'h1);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(`USBT_CTRL_OFF, r);
        chk("ctrl after reset", r, 32'h0);
        conclude();
    end
endmodule // usbt_matcher_tb
